// >>> design/dcts_top.sv
// Two capture/compare channels sharing three timers, with an AHB-Lite register slave.
//
// Functional notes
// RULE_01: Capture/compare use timer one or three; PWM two.
// RULE_02: Third timer control bits pick each channel's timer.
// RULE_03: Both channels may run and share a timer.
// RULE_04: Two PWM channels share second timer frequency.
// RULE_05: Special event timer reset seen by capture channel.
// RULE_06: Only channel two's trigger starts conversions.
// RULE_07: Open-drain bits in port g direction register.
// RULE_08: Pin select one: primary pin; zero: alternate.
// RULE_09: Capture copies full 16-bit selected timer count.
// RULE_10: Falling, rising, fourth or sixteenth rising edge.
// RULE_11: Capture sets flag; only software clears it.
// RULE_12: Newer capture overwrites unread held value.
// RULE_13: Output pin port write can cause capture.
// RULE_14: Software keeps the pin an input during capture.
// RULE_15: Software runs timer synchronously, never asynchronous counter.
// RULE_16: Capture mode change may raise a false flag.
// RULE_17: Prescaler cleared when off or not capturing.
// RULE_18: Prescaler kept when switching between capture settings.
// RULE_19: Codes 0100 to 0111 select capture edges.
// RULE_20: Code 0000 disables channel and resets it.
// RULE_21: Pin synchronised; value latched after qualified edge.
`timescale 1ns/1ps
`include "dcts_consts.svh"
module dcts_top
    import dcts_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic channel_two_pin_select,
    input wire logic ch1_pin_in,
    output logic ch1_pin_out,
    output logic ch1_pin_oe_n,
    input wire logic primary_channel_pin_in,
    output logic primary_channel_pin_out,
    output logic primary_channel_pin_oe_n,
    input wire logic alternate_channel_pin_in,
    output logic alternate_channel_pin_out,
    output logic alternate_channel_pin_oe_n,
    output logic adc_start
);
    dcts_top_s s_ff;
    dcts_top_s nxt_s;
    logic [1:0] capture_evt;
    logic [1:0] mode_glitch;
    logic [1:0] cap_level;
    logic [1:0] use_t3;
    logic [1:0] match;
    logic [1:0] special;
    logic [1:0] drive_val;
    logic [1:0] out_mode;
    logic [15:0] tb1;
    logic [15:0] tb2;
    logic t1_clr;
    logic t3_clr;
    logic t2_wrap;
    logic ch2_level;
    logic ch2_oe_n;
    logic ch2_val;
    logic addr_ok;

    dcts_cap_if cap1_if ();
    dcts_cap_if cap2_if ();

    // ------------------------------------------------------------
    // Capture channels
    // ------------------------------------------------------------
    dcts_capture_channel u_chan1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .cap(cap1_if.chan)
    );

    dcts_capture_channel u_chan2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .cap(cap2_if.chan)
    );

    assign cap1_if.mode = s_ff.mode1;
    assign cap2_if.mode = s_ff.mode2;
    assign cap1_if.pin_level = cap_level[0];
    assign cap2_if.pin_level = cap_level[1];
    assign capture_evt = {cap2_if.capture_evt, cap1_if.capture_evt};
    assign mode_glitch = {cap2_if.mode_glitch, cap1_if.mode_glitch};

    function automatic logic is_out_mode(input logic [3:0] m);
        is_out_mode = (m == `DCTS_MODE_CMP_TOGGLE) || (m == `DCTS_MODE_CMP_HIGH) ||
                      (m == `DCTS_MODE_CMP_LOW) || (m[3:2] == 2'b11);
    endfunction : is_out_mode

    function automatic logic is_cmp(input logic [3:0] m);
        is_cmp = (m == `DCTS_MODE_CMP_TOGGLE) || (m[3:2] == 2'b10);
    endfunction : is_cmp

    function automatic logic init_level(input logic [3:0] m, input logic cur);
        if (m == `DCTS_MODE_CMP_HIGH || m == `DCTS_MODE_OFF) begin
            init_level = 1'b0;
        end else if (m == `DCTS_MODE_CMP_LOW) begin
            init_level = 1'b1;
        end else begin
            init_level = cur;
        end
    endfunction : init_level

    // ------------------------------------------------------------
    // Timer routing and compare
    // ------------------------------------------------------------
    always_comb begin
        // Both set: channel one on timer three too; only low bit set: channel two alone moves.
        use_t3[0] = s_ff.t3_ch2; // [RULE_02]
        use_t3[1] = s_ff.t3_ch2 | s_ff.t3_ch1; // [RULE_02] [RULE_03]
        tb1 = use_t3[0] ? s_ff.t3 : s_ff.t1; // [RULE_01]
        tb2 = use_t3[1] ? s_ff.t3 : s_ff.t1;
        match[0] = is_cmp(s_ff.mode1) && (tb1 == s_ff.val1);
        match[1] = is_cmp(s_ff.mode2) && (tb2 == s_ff.val2);
        special[0] = match[0] && !s_ff.match_prev[0] && (s_ff.mode1 == `DCTS_MODE_CMP_SPECIAL);
        special[1] = match[1] && !s_ff.match_prev[1] && (s_ff.mode2 == `DCTS_MODE_CMP_SPECIAL);
        // A timer reset hits every channel on that timer, capture channels included.
        t1_clr = (special[0] && !use_t3[0]) || (special[1] && !use_t3[1]); // [RULE_05]
        t3_clr = (special[0] && use_t3[0]) || (special[1] && use_t3[1]); // [RULE_05]
        t2_wrap = (s_ff.t2 >= s_ff.t2_period);
        out_mode = {is_out_mode(s_ff.mode2), is_out_mode(s_ff.mode1)};
        drive_val[0] = out_mode[0] ? s_ff.cmp_out[0] : s_ff.latch[0];
        drive_val[1] = out_mode[1] ? s_ff.cmp_out[1] : s_ff.latch[1];
        ch2_level = s_ff.sel_sync[1] ? s_ff.pri_sync[1] : s_ff.alt_sync[1]; // [RULE_08]
        // A pin set as output feeds its own latch back, so a port write can capture.
        cap_level[0] = s_ff.dir[0] ? s_ff.ch1_sync[1] : drive_val[0]; // [RULE_13] [RULE_21]
        cap_level[1] = s_ff.dir[1] ? ch2_level : drive_val[1]; // [RULE_13]
        addr_ok = hsel && hready && htrans[1];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.hready = 1'b1;
        nxt_s.adc_start = special[1]; // [RULE_06]
        nxt_s.match_prev = match;
        nxt_s.sel_sync = {s_ff.sel_sync[0], channel_two_pin_select};
        nxt_s.ch1_sync = {s_ff.ch1_sync[0], ch1_pin_in};
        nxt_s.pri_sync = {s_ff.pri_sync[0], primary_channel_pin_in};
        nxt_s.alt_sync = {s_ff.alt_sync[0], alternate_channel_pin_in};

        if (s_ff.t1_run) begin
            nxt_s.t1 = s_ff.t1 + 16'h0001;
        end
        if (s_ff.t3_run) begin
            nxt_s.t3 = s_ff.t3 + 16'h0001;
        end
        if (t1_clr) begin
            nxt_s.t1 = 16'h0000;
        end
        if (t3_clr) begin
            nxt_s.t3 = 16'h0000;
        end
        nxt_s.t2 = t2_wrap ? 8'h00 : s_ff.t2 + 8'h01; // [RULE_04]

        // Compare outputs; PWM duty comes from the low value byte on the common second timer.
        for (int i = 0; i < 2; i++) begin
            if (match[i] && !s_ff.match_prev[i]) begin
                case (i == 0 ? s_ff.mode1 : s_ff.mode2)
                    `DCTS_MODE_CMP_TOGGLE: begin
                        nxt_s.cmp_out[i] = ~s_ff.cmp_out[i];
                    end
                    `DCTS_MODE_CMP_HIGH: begin
                        nxt_s.cmp_out[i] = 1'b1;
                    end
                    `DCTS_MODE_CMP_LOW: begin
                        nxt_s.cmp_out[i] = 1'b0;
                    end
                    default: begin
                        nxt_s.cmp_out[i] = s_ff.cmp_out[i];
                    end
                endcase
            end
        end
        if (s_ff.mode1[3:2] == 2'b11) begin
            nxt_s.cmp_out[0] = (s_ff.t2 < s_ff.val1[7:0]); // [RULE_01] [RULE_04]
        end
        if (s_ff.mode2[3:2] == 2'b11) begin
            nxt_s.cmp_out[1] = (s_ff.t2 < s_ff.val2[7:0]); // [RULE_04]
        end

        // Register write in the data phase.
        nxt_s.wr_pend = addr_ok && hwrite;
        nxt_s.wr_addr = haddr[7:0];
        if (s_ff.wr_pend) begin
            case (s_ff.wr_addr)
                `DCTS_OFS_CH1_CTRL: begin
                    nxt_s.mode1 = hwdata[3:0];
                    nxt_s.cmp_out[0] = init_level(hwdata[3:0], s_ff.cmp_out[0]); // [RULE_20]
                end
                `DCTS_OFS_CH2_CTRL: begin
                    nxt_s.mode2 = hwdata[3:0];
                    nxt_s.cmp_out[1] = init_level(hwdata[3:0], s_ff.cmp_out[1]); // [RULE_20]
                end
                `DCTS_OFS_CH1_VALUE: nxt_s.val1 = hwdata[15:0];
                `DCTS_OFS_CH2_VALUE: nxt_s.val2 = hwdata[15:0];
                `DCTS_OFS_T1_CTRL: nxt_s.t1_run = hwdata[`DCTS_T1_RUN_BIT];
                `DCTS_OFS_T3_CTRL: begin
                    nxt_s.t3_run = hwdata[`DCTS_T3_RUN_BIT];
                    nxt_s.t3_ch1 = hwdata[`DCTS_T3_CH1_BIT]; // [RULE_02]
                    nxt_s.t3_ch2 = hwdata[`DCTS_T3_CH2_BIT]; // [RULE_02]
                end
                // A software write to a timer wins over a special event reset.
                `DCTS_OFS_T1_COUNT: nxt_s.t1 = hwdata[15:0];
                `DCTS_OFS_T3_COUNT: nxt_s.t3 = hwdata[15:0];
                `DCTS_OFS_T2_PERIOD: nxt_s.t2_period = hwdata[7:0];
                `DCTS_OFS_IRQ_FLAGS: begin
                    nxt_s.flags = s_ff.flags & {hwdata[`DCTS_CH2_FLAG_BIT], hwdata[`DCTS_CH1_FLAG_BIT]};
                end
                `DCTS_OFS_IRQ_ENABLES: begin
                    nxt_s.enables = {hwdata[`DCTS_CH2_FLAG_BIT], hwdata[`DCTS_CH1_FLAG_BIT]};
                end
                `DCTS_OFS_PORT_G_DIR: begin
                    nxt_s.od = {hwdata[`DCTS_CH2_OD_BIT], hwdata[`DCTS_CH1_OD_BIT]}; // [RULE_07]
                end
                `DCTS_OFS_PORT_CTRL: begin
                    nxt_s.dir = {hwdata[`DCTS_DIR2_BIT], hwdata[`DCTS_DIR1_BIT]};
                    nxt_s.latch = {hwdata[`DCTS_LAT2_BIT], hwdata[`DCTS_LAT1_BIT]};
                end
                default: begin
                    nxt_s.wr_pend = nxt_s.wr_pend;
                end
            endcase
        end

        // Captures and flag sets come after the write so that hardware wins a same-cycle race.
        if (capture_evt[0]) begin
            nxt_s.val1 = tb1; // [RULE_09] [RULE_12] [RULE_21]
        end
        if (capture_evt[1]) begin
            nxt_s.val2 = tb2; // [RULE_09] [RULE_12]
        end
        for (int i = 0; i < 2; i++) begin
            if (capture_evt[i] || mode_glitch[i] || (match[i] && !s_ff.match_prev[i])) begin
                nxt_s.flags[i] = 1'b1; // [RULE_11] [RULE_16]
            end
        end

        // Pin drivers; open drain only releases the pin where a high would be driven.
        nxt_s.ch1_out = drive_val[0];
        nxt_s.ch1_oe_n = s_ff.dir[0] | (out_mode[0] & s_ff.od[0] & drive_val[0]); // [RULE_07]
        ch2_val = drive_val[1];
        ch2_oe_n = s_ff.dir[1] | (out_mode[1] & s_ff.od[1] & drive_val[1]); // [RULE_07]
        nxt_s.pri_out = s_ff.sel_sync[1] ? ch2_val : 1'b0; // [RULE_08]
        nxt_s.pri_oe_n = s_ff.sel_sync[1] ? ch2_oe_n : 1'b1;
        nxt_s.alt_out = s_ff.sel_sync[1] ? 1'b0 : ch2_val;
        nxt_s.alt_oe_n = s_ff.sel_sync[1] ? 1'b1 : ch2_oe_n;

        // Read data is prepared in the address phase so the slave never waits.
        nxt_s.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                `DCTS_OFS_CH1_CTRL: nxt_s.rdata[3:0] = s_ff.mode1;
                `DCTS_OFS_CH2_CTRL: nxt_s.rdata[3:0] = s_ff.mode2;
                `DCTS_OFS_CH1_VALUE: nxt_s.rdata[15:0] = s_ff.val1;
                `DCTS_OFS_CH2_VALUE: nxt_s.rdata[15:0] = s_ff.val2;
                `DCTS_OFS_T1_CTRL: nxt_s.rdata[`DCTS_T1_RUN_BIT] = s_ff.t1_run;
                `DCTS_OFS_T3_CTRL: begin
                    nxt_s.rdata[`DCTS_T3_RUN_BIT] = s_ff.t3_run;
                    nxt_s.rdata[`DCTS_T3_CH1_BIT] = s_ff.t3_ch1;
                    nxt_s.rdata[`DCTS_T3_CH2_BIT] = s_ff.t3_ch2;
                end
                `DCTS_OFS_T1_COUNT: nxt_s.rdata[15:0] = s_ff.t1;
                `DCTS_OFS_T3_COUNT: nxt_s.rdata[15:0] = s_ff.t3;
                `DCTS_OFS_T2_PERIOD: nxt_s.rdata[7:0] = s_ff.t2_period;
                `DCTS_OFS_T2_COUNT: nxt_s.rdata[7:0] = s_ff.t2;
                `DCTS_OFS_IRQ_FLAGS: begin
                    nxt_s.rdata[`DCTS_CH1_FLAG_BIT] = s_ff.flags[0];
                    nxt_s.rdata[`DCTS_CH2_FLAG_BIT] = s_ff.flags[1];
                end
                `DCTS_OFS_IRQ_ENABLES: begin
                    nxt_s.rdata[`DCTS_CH1_FLAG_BIT] = s_ff.enables[0];
                    nxt_s.rdata[`DCTS_CH2_FLAG_BIT] = s_ff.enables[1];
                end
                `DCTS_OFS_PORT_G_DIR: begin
                    nxt_s.rdata[`DCTS_CH1_OD_BIT] = s_ff.od[0];
                    nxt_s.rdata[`DCTS_CH2_OD_BIT] = s_ff.od[1];
                end
                `DCTS_OFS_PORT_CTRL: begin
                    nxt_s.rdata[`DCTS_DIR1_BIT] = s_ff.dir[0];
                    nxt_s.rdata[`DCTS_DIR2_BIT] = s_ff.dir[1];
                    nxt_s.rdata[`DCTS_LAT1_BIT] = s_ff.latch[0];
                    nxt_s.rdata[`DCTS_LAT2_BIT] = s_ff.latch[1];
                end
                default: nxt_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
            s_ff.hready <= 1'b1;
            s_ff.t2_period <= `DCTS_RST_T2_PERIOD;
            s_ff.dir <= `DCTS_RST_PORT_DIR;
            s_ff.ch1_oe_n <= 1'b1;
            s_ff.pri_oe_n <= 1'b1;
            s_ff.alt_oe_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hreadyout = s_ff.hready;
    assign hrdata = s_ff.rdata;
    assign hresp = 1'b0;
    assign ch1_pin_out = s_ff.ch1_out;
    assign ch1_pin_oe_n = s_ff.ch1_oe_n;
    assign primary_channel_pin_out = s_ff.pri_out;
    assign primary_channel_pin_oe_n = s_ff.pri_oe_n;
    assign alternate_channel_pin_out = s_ff.alt_out;
    assign alternate_channel_pin_oe_n = s_ff.alt_oe_n;
    assign adc_start = s_ff.adc_start;
endmodule : dcts_top

// >>> design/dcts_consts.svh
// Constants of the dual capture timer select block: offsets, bit positions, codes and reset values.
`ifndef DCTS_CONSTS_SVH
`define DCTS_CONSTS_SVH
`define DCTS_OFS_CH1_CTRL 8'h00
`define DCTS_OFS_CH2_CTRL 8'h04
`define DCTS_OFS_CH1_VALUE 8'h08
`define DCTS_OFS_CH2_VALUE 8'h0c
`define DCTS_OFS_T1_CTRL 8'h10
`define DCTS_OFS_T3_CTRL 8'h14
`define DCTS_OFS_T1_COUNT 8'h18
`define DCTS_OFS_T3_COUNT 8'h1c
`define DCTS_OFS_T2_PERIOD 8'h20
`define DCTS_OFS_T2_COUNT 8'h24
`define DCTS_OFS_IRQ_FLAGS 8'h28
`define DCTS_OFS_IRQ_ENABLES 8'h2c
`define DCTS_OFS_PORT_G_DIR 8'h30
`define DCTS_OFS_PORT_CTRL 8'h34
`define DCTS_T1_RUN_BIT 0
`define DCTS_T3_RUN_BIT 0
`define DCTS_T3_CH1_BIT 3
`define DCTS_T3_CH2_BIT 6
`define DCTS_CH1_FLAG_BIT 1
`define DCTS_CH2_FLAG_BIT 2
`define DCTS_CH1_OD_BIT 5
`define DCTS_CH2_OD_BIT 6
`define DCTS_DIR1_BIT 0
`define DCTS_DIR2_BIT 1
`define DCTS_LAT1_BIT 4
`define DCTS_LAT2_BIT 5
`define DCTS_MODE_OFF 4'h0
`define DCTS_MODE_CMP_TOGGLE 4'h2
`define DCTS_MODE_CAP_FALL 4'h4
`define DCTS_MODE_CAP_RISE 4'h5
`define DCTS_MODE_CAP_RISE4 4'h6
`define DCTS_MODE_CAP_RISE16 4'h7
`define DCTS_MODE_CMP_HIGH 4'h8
`define DCTS_MODE_CMP_LOW 4'h9
`define DCTS_MODE_CMP_SOFT 4'ha
`define DCTS_MODE_CMP_SPECIAL 4'hb
`define DCTS_PRESCALE_4_LAST 4'h3
`define DCTS_PRESCALE_16_LAST 4'hf
`define DCTS_RST_T2_PERIOD 8'hff
`define DCTS_RST_PORT_DIR 2'h3
`endif

// >>> design/dcts_pkg.sv
// Types shared by the dual capture timer select block.
package dcts_pkg;
    typedef struct packed {
        logic level_prev;
        logic [3:0] cnt;
        logic evt;
        logic glitch;
        logic [3:0] mode_prev;
    } dcts_chan_s;

    typedef struct packed {
        logic [3:0] mode1;
        logic [3:0] mode2;
        logic [15:0] val1;
        logic [15:0] val2;
        logic [15:0] t1;
        logic [15:0] t3;
        logic t1_run;
        logic t3_run;
        logic t3_ch1;
        logic t3_ch2;
        logic [7:0] t2;
        logic [7:0] t2_period;
        logic [1:0] flags;
        logic [1:0] enables;
        logic [1:0] od;
        logic [1:0] dir;
        logic [1:0] latch;
        logic [1:0] cmp_out;
        logic [1:0] match_prev;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic hready;
        logic adc_start;
        logic ch1_out;
        logic ch1_oe_n;
        logic pri_out;
        logic pri_oe_n;
        logic alt_out;
        logic alt_oe_n;
        logic [1:0] sel_sync;
        logic [1:0] ch1_sync;
        logic [1:0] pri_sync;
        logic [1:0] alt_sync;
    } dcts_top_s;
endpackage : dcts_pkg

// >>> design/dcts_cap_if.sv
// Link between the top block and one capture channel.
`timescale 1ns/1ps
interface dcts_cap_if;
    logic [3:0] mode;
    logic pin_level;
    logic capture_evt;
    logic mode_glitch;
    modport chan (input mode, input pin_level, output capture_evt, output mode_glitch);
    modport host (output mode, output pin_level, input capture_evt, input mode_glitch);
endinterface : dcts_cap_if

// >>> design/dcts_capture_channel.sv
// Edge qualification and capture prescaler of one channel.
`timescale 1ns/1ps
`include "dcts_consts.svh"
module dcts_capture_channel
    import dcts_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    dcts_cap_if.chan cap
);
    dcts_chan_s s_ff;
    dcts_chan_s nxt_s;
    logic is_cap;
    logic rise;
    logic fall;
    logic [3:0] last;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.evt = 1'b0;
        nxt_s.glitch = 1'b0;
        nxt_s.level_prev = cap.pin_level;
        nxt_s.mode_prev = cap.mode;
        is_cap = (cap.mode[3:2] == 2'b01);
        rise = cap.pin_level & ~s_ff.level_prev; // [RULE_21]
        fall = ~cap.pin_level & s_ff.level_prev;
        last = (cap.mode == `DCTS_MODE_CAP_RISE4) ? `DCTS_PRESCALE_4_LAST : `DCTS_PRESCALE_16_LAST;
        if (!is_cap) begin
            nxt_s.cnt = 4'h0; // [RULE_17] [RULE_20]
        end else begin
            // The counter is kept across a prescaler change, so the first event may come early.
            if (cap.mode != s_ff.mode_prev && s_ff.mode_prev[3:2] == 2'b01) begin
                nxt_s.glitch = 1'b1; // [RULE_16] [RULE_18]
            end
            case (cap.mode) // [RULE_10] [RULE_19]
                `DCTS_MODE_CAP_FALL: begin
                    nxt_s.evt = fall;
                end
                `DCTS_MODE_CAP_RISE: begin
                    nxt_s.evt = rise;
                end
                default: begin
                    if (rise) begin
                        if (s_ff.cnt >= last) begin
                            nxt_s.evt = 1'b1;
                            nxt_s.cnt = 4'h0;
                        end else begin
                            nxt_s.cnt = s_ff.cnt + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign cap.capture_evt = s_ff.evt;
    assign cap.mode_glitch = s_ff.glitch;
endmodule : dcts_capture_channel

// >>> test/dcts_pin_src.sv
// Partner model: source of the three capture pin levels.
`timescale 1ns/1ps
module dcts_pin_src (
    input logic hclk,
    input logic [2:0] want,
    output logic [2:0] lvl
);
    initial lvl = 3'h0;
    always @(posedge hclk) begin
        lvl <= want;
    end
endmodule : dcts_pin_src

// >>> test/dcts_top_checker.sv
// Assertions bound to the capture timer top.
`timescale 1ns/1ps
module dcts_top_checker (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [31:0] hwdata,
    input logic hready,
    input logic [31:0] hrdata,
    input logic channel_two_pin_select,
    input logic ch1_pin_out,
    input logic ch1_pin_oe_n,
    input logic primary_channel_pin_out,
    input logic primary_channel_pin_oe_n,
    input logic alternate_channel_pin_out,
    input logic alternate_channel_pin_oe_n,
    input logic adc_start
);
    // Control fields shadowed from the bus.
    logic ph_ff;
    logic [7:0] pa_ff;
    logic [3:0] m1_ff, m2_ff;
    logic [1:0] dir_ff, od_ff;
    logic om1;
    assign om1 = (m1_ff == 4'h2) || (m1_ff[3] && m1_ff[2:1] != 2'b01);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_ff <= 1'b0;
            pa_ff <= 8'h0;
            m1_ff <= 4'h0;
            m2_ff <= 4'h0;
            dir_ff <= 2'h3;
            od_ff <= 2'h0;
        end else if (hready) begin
            ph_ff <= hsel && htrans[1] && hwrite;
            pa_ff <= haddr[7:0];
            if (ph_ff) begin
                case (pa_ff)
                    8'h00: m1_ff <= hwdata[3:0];
                    8'h04: m2_ff <= hwdata[3:0];
                    8'h30: od_ff <= hwdata[6:5];
                    8'h34: dir_ff <= hwdata[1:0];
                    default: ;
                endcase
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    adc_ch2_a: assert property (adc_start |-> $past(m2_ff) == 4'hb)
        else $error("adc without trigger");
    adc_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("adc pulse too long");
    input_pin_a: assert property (dir_ff[0] [*3] |-> ch1_pin_oe_n)
        else $error("input pin driven");
    push_pull_a: assert property ((!dir_ff[0] && !od_ff[0]) [*3] |-> !ch1_pin_oe_n)
        else $error("pin not driven");
    open_drain_a: assert property ((!dir_ff[0] && od_ff[0] && om1) [*3] |-> ch1_pin_oe_n == ch1_pin_out)
        else $error("open drain drives high");
    unsel_pri_a: assert property (!channel_two_pin_select [*4] |=> primary_channel_pin_oe_n && !primary_channel_pin_out)
        else $error("primary pin used");
    unsel_alt_a: assert property (channel_two_pin_select [*4] |=> alternate_channel_pin_oe_n && !alternate_channel_pin_out)
        else $error("alternate pin used");
    read_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
        else $error("stray read data");
endmodule : dcts_top_checker
bind dcts_top dcts_top_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .channel_two_pin_select(channel_two_pin_select),
    .ch1_pin_out(ch1_pin_out), .ch1_pin_oe_n(ch1_pin_oe_n), .primary_channel_pin_out(primary_channel_pin_out),
    .primary_channel_pin_oe_n(primary_channel_pin_oe_n), .alternate_channel_pin_out(alternate_channel_pin_out),
    .alternate_channel_pin_oe_n(alternate_channel_pin_oe_n), .adc_start(adc_start));

// >>> test/test_dual_capture_timer_select.sv
// Self-checking bench for the capture timer block.
`timescale 1ns/1ps
module test_dual_capture_timer_select;
    logic hclk, hresetn, hsel, hwrite, strap, hreadyout, hresp, adc_start, o1, e1, op, ep, oa, ea;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, want, lvl;
    int n_mismatch = 0, checks = 0, n_adc = 0, n;
    dcts_pin_src src (.hclk(hclk), .want(want), .lvl(lvl));
    dcts_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .channel_two_pin_select(strap), .ch1_pin_in(e1 ? lvl[0] : o1), .ch1_pin_out(o1), .ch1_pin_oe_n(e1),
        .primary_channel_pin_in(ep ? lvl[1] : op), .primary_channel_pin_out(op), .primary_channel_pin_oe_n(ep),
        .alternate_channel_pin_in(ea ? lvl[2] : oa), .alternate_channel_pin_out(oa),
        .alternate_channel_pin_oe_n(ea), .adc_start(adc_start));
    // ------------
    // Bus and pin tasks
    // ------------
    task automatic cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask : cyc
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic pulse(input logic [2:0] m, input int c);
        repeat (c) begin
            want <= m;
            cyc(6);
            want <= 3'h0;
            cyc(6);
        end
    endtask : pulse
    // Channel one in mode m flags on the c-th qualified edge only.
    task automatic fire(input logic [3:0] m, input int c);
        wr(8'h00, {28'h0, m});
        cyc(4);
        wr(8'h28, 32'h0);
        pulse(3'h1, c - 1);
        rdc(8'h28, 32'h0);
        want <= 3'h1;
        cyc(6);
        rdc(8'h28, m == 4'h4 ? 32'h0 : 32'h2);
        want <= 3'h0;
        cyc(6);
        rdc(8'h28, 32'h2);
    endtask : fire
    task automatic close_out;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk)
        if (adc_start === 1'b1) n_adc++;
    initial begin
        #500000;
        n_mismatch++;
        close_out();
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, want} = '0;
        hsize = 3'h2;
        strap = 1'b1;
        cyc(8);
        hresetn <= 1'b1;
        rdc(8'h20, 32'hff);
        rdc(8'h34, 32'h3);
        rdc(8'h04, 32'h0);
        wr(8'h18, 32'hbeef);
        wr(8'h1c, 32'h5a3c);
        wr(8'h00, 32'h5);
        wr(8'h04, 32'h5);
        cyc(4);
        for (int i = 2; i >= 0; i--) begin
            wr(8'h14, i == 0 ? 32'h0 : (i == 1 ? 32'h8 : 32'h40));
            pulse(3'h3, 1);
            rdc(8'h08, i == 2 ? 32'h5a3c : 32'hbeef);
            rdc(8'h0c, i == 0 ? 32'hbeef : 32'h5a3c);
        end
        rdc(8'h28, 32'h6);
        wr(8'h28, 32'h6);
        rdc(8'h28, 32'h6);
        wr(8'h04, 32'h0);
        for (int m = 4; m < 8; m++) begin
            wr(8'h00, 32'h0);
            fire(m[3:0], m == 6 ? 4 : (m == 7 ? 16 : 1));
        end
        wr(8'h00, 32'h6);
        pulse(3'h1, 2);
        fire(4'h7, 14);
        wr(8'h00, 32'h5);
        cyc(4);
        wr(8'h28, 32'h0);
        wr(8'h34, 32'h2);
        wr(8'h34, 32'h12);
        cyc(6);
        rdc(8'h28, 32'h2);
        chk({30'h0, hresp, e1}, 32'h0);
        wr(8'h30, 32'h20);
        wr(8'h18, 32'h0);
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h8);
        cyc(3);
        chk({31'h0, e1}, 32'h0);
        wr(8'h10, 32'h1);
        cyc(40);
        chk({31'h0, e1}, 32'h1);
        wr(8'h34, 32'h3);
        wr(8'h00, 32'h5);
        wr(8'h0c, 32'h40);
        wr(8'h18, 32'h0);
        wr(8'h04, 32'hb);
        cyc(300);
        chk({31'h0, n_adc > 0}, 32'h1);
        pulse(3'h1, 1);
        bus(1'b0, 8'h08, 32'h0);
        chk({31'h0, rd <= 32'h40}, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h30);
        wr(8'h18, 32'h0);
        n = n_adc;
        wr(8'h00, 32'hb);
        cyc(300);
        chk(n_adc, n);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h5);
        strap <= 1'b0;
        cyc(6);
        wr(8'h28, 32'h0);
        pulse(3'h2, 1);
        rdc(8'h28, 32'h0);
        pulse(3'h4, 1);
        rdc(8'h28, 32'h4);
        close_out();
    end
endmodule : test_dual_capture_timer_select
